// File: core/fuse_config_and_debug_lock.sv
`timescale 1ns/1ps
`default_nettype none
// Contract
// (R1) check region select picks scanned flash
// (R2) reset pin: 0 gpio, 1 reset
// (R3) keep bit spares eeprom on erase
// (R4) locked erase always clears eeprom
// (R5) startup delay 0 or 1..64 ms
// (R6) app limit ends code, 256-byte blocks
// (R7) flash above app limit is data
// (R8) app limit zero: code to top
// (R9) boot limit ends boot, 256-byte blocks
// (R10) boot limit zero: all flash boot
// (R11) open only when key equals c5
// (R12) locked port denied system bus
// (R13) unlocked access table for cpu, port
// (R14) locked port blocked from all memories except blind customer row writes
// (R15) locked: blind customer row writes allowed
// (R16) denied port reads return corrupted data
// (R17) only full erase leaves locked state
// (R18) fuses copied at end of startup
// (R19) fuse changes act after next reset
// (R20) cpu reads fuses, port programs them
// (R21) classify flash address by limits
module fuse_config_and_debug_lock
(
   input wire logic mclk,
   input wire logic rst,
   // nonvolatile fuse array contents, indexed by offset
   input wire logic [7:0] fuse_array [0:15],
   // cpu fuse read port
   input wire logic cpu_fuse_rd,
   input wire logic [3:0] cpu_fuse_addr,
   output logic [7:0] cpu_fuse_rdata,
   // cpu memory access check
   input wire fuse_cfg_pkg::mem_req_t cpu_req,
   output logic cpu_grant,
   // debug port access check
   input wire fuse_cfg_pkg::mem_req_t dbg_req,
   output logic dbg_grant,
   output logic dbg_corrupt_read,
   input wire logic [7:0] dbg_mem_rdata,
   output logic [7:0] dbg_rdata,
   output logic dbg_fuse_prog_en,
   // full device erase
   input wire logic erase_req,
   output logic erase_eeprom,
   output logic erase_all,
   // flash classification
   input wire logic [15:0] flash_addr,
   output fuse_cfg_pkg::flash_section_t flash_section,
   output logic [15:0] check_end_addr,
   output logic check_enable,
   // captured configuration
   output logic reset_pin_is_reset,
   output logic locked,
   output logic startup_done
);
   typedef enum logic [1:0]
   {
      st_load = 2'b00,
      st_wait = 2'b01,
      st_run = 2'b11
   } state_t;

   state_t state;
   state_t next_state;
   fuse_cfg_pkg::fuse_cfg_t cfg;
   fuse_cfg_pkg::fuse_cfg_t next_cfg;
   logic [16:0] ms_count;
   logic [6:0] ms_left;
   logic ms_tick;
   logic [7:0] fuse_b0;
   logic [7:0] fuse_b1;
   logic [6:0] delay_ms;

   // delay in ms for a select code, zero for code 0
   function automatic logic [6:0] delay_of(input logic [2:0] sel);
      logic [6:0] d;
      d = 7'h00;
      if (sel != 3'h0)
      begin
         d = 7'h01 << (sel - 3'h1);
      end
      return d;
   endfunction

   // raw bytes gathered into one configuration word
   assign fuse_b0 = fuse_array[fuse_cfg_pkg::off_reset_boot_options];
   assign fuse_b1 = fuse_array[fuse_cfg_pkg::off_startup_timing_config];
   assign next_cfg.flash_check_region_select =
      fuse_b0[fuse_cfg_pkg::check_sel_hi:fuse_cfg_pkg::check_sel_lo];
   assign next_cfg.reset_pin_function_select = fuse_b0[fuse_cfg_pkg::reset_pin_bit];
   assign next_cfg.keep_eeprom_on_erase = fuse_b0[fuse_cfg_pkg::keep_eeprom_bit];
   assign next_cfg.startup_delay_select = fuse_b1[fuse_cfg_pkg::startup_sel_hi:0];
   assign next_cfg.application_region_limit = fuse_array[fuse_cfg_pkg::off_app_region_end];
   assign next_cfg.boot_region_limit = fuse_array[fuse_cfg_pkg::off_boot_region_end];
   assign next_cfg.lock_key = fuse_array[fuse_cfg_pkg::off_debug_lock_key];
   assign delay_ms = delay_of(next_cfg.startup_delay_select); // see (R5)

   // millisecond tick divider, runs only while waiting
   assign ms_tick = (ms_count == 17'(fuse_cfg_pkg::cycles_per_ms - 1));

   always_comb
   begin
      next_state = state;
      unique case (state)
         st_load: next_state = (delay_ms == 7'h00) ? st_run : st_wait; // see (R5)
         st_wait: next_state = (ms_tick && ms_left == 7'h01) ? st_run : st_wait;
         st_run: next_state = st_run;
      endcase
   end

   // state and delay counters
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         state <= st_load;
         ms_count <= 17'h00000;
         ms_left <= 7'h00;
      end
      else
      begin
         state <= next_state;
         if (state == st_load)
         begin
            ms_left <= delay_ms;
            ms_count <= 17'h00000;
         end
         else if (state == st_wait)
         begin
            ms_count <= ms_tick ? 17'h00000 : ms_count + 17'h00001;
            if (ms_tick)
            begin
               ms_left <= ms_left - 7'h01;
            end
         end
      end
   end

   // capture once at the end of startup; later fuse edits wait for reset
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         cfg <= '1; // locked and safe until captured
      end
      else if (state != st_run && next_state == st_run)
      begin
         cfg <= next_cfg; // see (R18) (R19)
      end
   end

   assign startup_done = (state == st_run);
   // key check; anything but the open key locks
   assign locked = (cfg.lock_key != fuse_cfg_pkg::open_key); // see (R11)
   assign reset_pin_is_reset = cfg.reset_pin_function_select; // see (R2)

   // flash section boundaries
   logic [15:0] boot_end;
   logic [15:0] app_end;
   assign boot_end = {cfg.boot_region_limit, 8'h00}; // see (R9)
   assign app_end = {cfg.application_region_limit, 8'h00}; // see (R6)
   assign flash_section =
      (cfg.boot_region_limit == 8'h00) ? fuse_cfg_pkg::sec_boot : // see (R10)
      (flash_addr < boot_end) ? fuse_cfg_pkg::sec_boot : // see (R21)
      (cfg.application_region_limit == 8'h00) ? fuse_cfg_pkg::sec_app_code : // see (R8)
      (flash_addr < app_end) ? fuse_cfg_pkg::sec_app_code : // see (R6)
      fuse_cfg_pkg::sec_app_data; // see (R7)

   // scan checker range; end address is exclusive, 0 means whole flash
   logic boot_all;
   logic code_to_top;
   assign boot_all = (cfg.boot_region_limit == 8'h00);
   assign code_to_top = (cfg.application_region_limit == 8'h00);
   assign check_enable = startup_done &&
      (cfg.flash_check_region_select != fuse_cfg_pkg::skip_flash_check); // see (R1)
   always_comb
   begin
      check_end_addr = 16'h0000;
      unique case (cfg.flash_check_region_select) // see (R1)
         fuse_cfg_pkg::check_full: check_end_addr = 16'h0000;
         fuse_cfg_pkg::check_boot: check_end_addr = boot_all ? 16'h0000 : boot_end;
         fuse_cfg_pkg::boot_plus_code_check:
            check_end_addr = (boot_all || code_to_top) ? 16'h0000 : app_end;
         fuse_cfg_pkg::skip_flash_check: check_end_addr = 16'h0000;
      endcase
   end

   // cpu: reads all, never writes signature row or fuses
   assign cpu_grant = cpu_req.valid && !(cpu_req.write &&
      (cpu_req.target == fuse_cfg_pkg::mem_signature_row ||
       cpu_req.target == fuse_cfg_pkg::mem_fuses)); // see (R13) (R14) (R20)

   // debug port rights depend on the lock; internal space always reachable
   logic dbg_open_ok;
   logic dbg_locked_ok;
   assign dbg_open_ok = !(dbg_req.write && dbg_req.target == fuse_cfg_pkg::mem_signature_row);
   assign dbg_locked_ok = (dbg_req.target == fuse_cfg_pkg::mem_port_internal) || // see (R12)
      (dbg_req.write && dbg_req.target == fuse_cfg_pkg::mem_customer_row); // see (R15)
   assign dbg_grant = dbg_req.valid &&
      (locked ? dbg_locked_ok : dbg_open_ok); // see (R13) (R14)
   // denied reads still complete, but carry garbage, not an error
   assign dbg_corrupt_read = dbg_req.valid && !dbg_req.write && !dbg_grant; // see (R16)
   assign dbg_fuse_prog_en = dbg_req.valid && dbg_req.write && dbg_grant &&
      (dbg_req.target == fuse_cfg_pkg::mem_fuses ||
       dbg_req.target == fuse_cfg_pkg::mem_customer_row); // see (R20)

   // registered read data; scrambled by a free-running lfsr when denied
   logic [7:0] scramble;
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         scramble <= 8'ha5;
         dbg_rdata <= 8'h00;
         cpu_fuse_rdata <= 8'h00;
      end
      else
      begin
         scramble <= {scramble[6:0], scramble[7] ^ scramble[5] ^ scramble[4] ^ scramble[3]};
         // low bit forced so a denied read can never hand back the true byte
         dbg_rdata <= dbg_corrupt_read ? (dbg_mem_rdata ^ (scramble | 8'h01)) : dbg_mem_rdata; // see (R16)
         if (cpu_fuse_rd)
         begin
            cpu_fuse_rdata <= fuse_array[cpu_fuse_addr]; // see (R20)
         end
      end
   end

   // erase effects; a lock is lifted only by a reset after the erase, never by the erase itself
   assign erase_all = erase_req; // see (R17)
   assign erase_eeprom = erase_req &&
      (locked || !cfg.keep_eeprom_on_erase); // see (R3) (R4)
endmodule
`default_nettype wire

// File: core/fuse_cfg_pkg.sv
package fuse_cfg_pkg;
   // fuse byte offsets
   localparam logic [3:0] off_reset_boot_options = 4'h5;
   localparam logic [3:0] off_startup_timing_config = 4'h6;
   localparam logic [3:0] off_app_region_end = 4'h7;
   localparam logic [3:0] off_boot_region_end = 4'h8;
   localparam logic [3:0] off_debug_lock_key = 4'ha;
   // field positions
   localparam int check_sel_hi = 7;
   localparam int check_sel_lo = 6;
   localparam int reset_pin_bit = 3;
   localparam int keep_eeprom_bit = 0;
   localparam int startup_sel_hi = 2;
   // encodings and values
   localparam logic [7:0] open_key = 8'hc5;
   localparam logic [1:0] check_full = 2'h0;
   localparam logic [1:0] check_boot = 2'h1;
   localparam logic [1:0] boot_plus_code_check = 2'h2;
   localparam logic [1:0] skip_flash_check = 2'h3;
   localparam int block_shift = 8; // 256-byte blocks
   localparam int flash_aw = 16;
   // timing: one millisecond tick at 100 MHz
   localparam int clk_mhz = 100;
   localparam int ms_us = 1000;
   localparam int cycles_per_ms = clk_mhz * ms_us;
   localparam int max_delay_ms = 64;

   typedef enum logic [1:0]
   {
      sec_boot = 2'h0,
      sec_app_code = 2'h1,
      sec_app_data = 2'h2
   } flash_section_t;

   typedef enum logic [2:0]
   {
      mem_sram = 3'h0,
      mem_regs = 3'h1,
      mem_flash = 3'h2,
      mem_eeprom = 3'h3,
      mem_customer_row = 3'h4,
      mem_signature_row = 3'h5,
      mem_fuses = 3'h6,
      mem_port_internal = 3'h7
   } mem_target_t;

   typedef struct packed
   {
      logic [1:0] flash_check_region_select;
      logic reset_pin_function_select;
      logic keep_eeprom_on_erase;
      logic [2:0] startup_delay_select;
      logic [7:0] application_region_limit;
      logic [7:0] boot_region_limit;
      logic [7:0] lock_key;
   } fuse_cfg_t;

   typedef struct packed
   {
      logic valid;
      logic write;
      mem_target_t target;
   } mem_req_t;
endpackage

// File: dv/fuse_lock_props.sv
`timescale 1ns/1ps
`default_nettype none
module fuse_lock_props
(
   input wire logic mclk,
   input wire logic rst,
   input wire fuse_cfg_pkg::mem_req_t cpu_req,
   input wire logic cpu_grant,
   input wire fuse_cfg_pkg::mem_req_t dbg_req,
   input wire logic dbg_grant,
   input wire logic dbg_corrupt_read,
   input wire logic [7:0] dbg_mem_rdata,
   input wire logic [7:0] dbg_rdata,
   input wire logic erase_req,
   input wire logic erase_eeprom,
   input wire logic locked,
   input wire logic startup_done
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   // target codes: 4 customer row, 5 signature, 6 fuses, 7 port internal
   wire logic [2:0] dt = dbg_req.target;
   // a port read, granted or not; the data shows one edge later
   sequence s_read(ok);
      dbg_req.valid && !dbg_req.write && dbg_grant == ok;
   endsequence
   chk_read_data: assert property (s_read(1) |=> dbg_rdata == $past(dbg_mem_rdata))
      else $error("granted read data lost");
   chk_read_corrupt: assert property (s_read(0) |-> dbg_corrupt_read
      ##1 dbg_rdata != $past(dbg_mem_rdata)) else $error("denied read not scrambled");
   chk_locked_block: assert property (locked && dbg_req.valid && dt != 3'h7
      && !(dbg_req.write && dt == 3'h4) |-> !dbg_grant) else $error("locked port granted");
   chk_blind_row: assert property (locked && dbg_req.valid && dbg_req.write && dt == 3'h4
      |-> dbg_grant) else $error("blind row write refused");
   chk_open_port: assert property (!locked && dbg_req.valid
      && !(dbg_req.write && dt == 3'h5) |-> dbg_grant) else $error("open port refused");
   chk_cpu_rights: assert property (cpu_req.valid |-> cpu_grant
      == !(cpu_req.write && cpu_req.target inside {3'h5, 3'h6})) else $error("cpu grant wrong");
   chk_locked_erase: assert property (erase_req && locked |-> erase_eeprom)
      else $error("locked erase kept eeprom");
   chk_cfg_holds: assert property (startup_done && $past(startup_done) |-> $stable(locked))
      else $error("lock changed without reset");
endmodule
bind fuse_config_and_debug_lock fuse_lock_props chk_u (.*);
`default_nettype wire

// File: dv/dbg_host.sv
`timescale 1ns/1ps
`default_nettype none
module dbg_host
(
   input wire logic go,
   input wire logic wr,
   input wire logic wipe,
   input wire fuse_cfg_pkg::mem_target_t tgt,
   output fuse_cfg_pkg::mem_req_t dbg_req,
   output logic erase_req
);
   // request held while the bench holds go; fuse writes only from here, customer row writes also from the cpu
   assign dbg_req = '{valid: go, write: wr, target: tgt};
   // erase is the one way back from locked
   assign erase_req = wipe;
endmodule
`default_nettype wire

// File: dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic mclk, rst, cpu_fuse_rd, go, wr, wipe, cpu_grant, dbg_grant, dbg_corrupt_read, erase_all;
   logic dbg_fuse_prog_en, erase_req, erase_eeprom, check_enable, reset_pin_is_reset, locked;
   logic startup_done;
   logic [7:0] fuse_array [0:15];
   logic [7:0] cpu_fuse_rdata, dbg_mem_rdata, dbg_rdata, bt, ap;
   logic [15:0] flash_addr, check_end_addr;
   logic [3:0] cpu_fuse_addr;
   fuse_cfg_pkg::mem_req_t cpu_req, dbg_req;
   fuse_cfg_pkg::mem_target_t tgt;
   fuse_cfg_pkg::flash_section_t flash_section;
   int err_count = 0, comparisons = 0, cycles = 0, c, k;
   fuse_config_and_debug_lock dut_u (.*);
   dbg_host host_u (.*);
   initial
   begin
      mclk = 0;
      forever #5 mclk = ~mclk;
   end
   task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         err_count++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic report_and_stop;
      $display("comparisons %0d err_count %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // hang guard, well above the hundred or so cycles needed
   always @(posedge mclk)
   begin
      cycles++;
      if (cycles > 2000)
      begin
         err_count++;
         report_and_stop;
      end
   end
   // reference section: 0 boot, 1 code, 2 data
   function automatic logic [1:0] sec(logic [15:0] a);
      if (bt == 8'h00 || a < {bt, 8'h00})
         return 2'h0;
      return (ap == 8'h00 || a < {ap, 8'h00}) ? 2'h1 : 2'h2;
   endfunction
   // reference port rights for the current write flag
   function automatic logic port_ok(logic lk, logic [2:0] t);
      return t == 3'h7 || (lk ? wr && t == 3'h4 : !(wr && t == 3'h5));
   endfunction
   // new fuses only act through a reset; startup code 0 keeps it short
   task automatic boot(logic [7:0] cfg0, logic [7:0] key);
      @(negedge mclk);
      fuse_array[5] = cfg0;
      fuse_array[6] = 8'h00;
      fuse_array[7] = ap;
      fuse_array[8] = bt;
      fuse_array[10] = key;
      rst = 1;
      repeat (2) @(negedge mclk);
      rst = 0;
      repeat (3) @(negedge mclk);
      check("startup", startup_done, 1);
   endtask
   initial
   begin
      void'($urandom(32'h161f4fdf));
      foreach (fuse_array[i])
         fuse_array[i] = 8'hff;
      rst = 1;
      {cpu_fuse_rd, go, wr, wipe} = 4'h0;
      cpu_fuse_addr = 4'h0;
      cpu_req = '0;
      dbg_mem_rdata = 8'h00;
      flash_addr = 16'h0000;
      tgt = fuse_cfg_pkg::mem_sram;
      // every check region, pin mode, keep bit; limits at their edges
      for (c = 0; c < 4; c++)
      begin
         bt = c == 3 ? 8'h00 : 8'h10;
         ap = c == 0 ? 8'h00 : 8'h40;
         boot({c[1:0], 2'h0, c[0], 2'h0, c[1]}, 8'hc5);
         check("pin", reset_pin_is_reset, c[0]);
         check("scan_on", check_enable, c != 3);
         if (c < 3)
            check("scan_end", check_end_addr, c == 1 ? 16'h1000 : {ap, 8'h00});
         wipe = 1;
         #1 check("ee_wipe", erase_eeprom, !c[1]);
         check("erase_all", erase_all, 1);
         wipe = 0;
         for (k = 0; k < 8; k++)
         begin
            @(negedge mclk);
            flash_addr = k < 4 ? {k[1] ? ap : bt, 8'h00} - 16'(k[0]) : 16'($urandom);
            #1 check("section", flash_section, sec(flash_addr));
         end
      end
      // rights open then locked; c4 sits one off the open key
      bt = 8'h10;
      ap = 8'h40;
      for (c = 0; c < 2; c++)
      begin
         boot(8'h01, c[0] ? 8'hc4 : 8'hc5);
         check("locked", locked, c[0]);
         wipe = 1;
         #1 check("ee_lock", erase_eeprom, c[0]);
         wipe = 0;
         cpu_fuse_rd = 1;
         cpu_fuse_addr = 4'h7;
         fuse_array[10] = 8'h00;
         @(negedge mclk);
         cpu_fuse_rd = 0;
         check("fuse_rd", cpu_fuse_rdata, 8'h40);
         check("cfg_held", locked, c[0]);
         for (k = 0; k < 16; k++)
         begin
            tgt = fuse_cfg_pkg::mem_target_t'(k[3:1]);
            wr = k[0];
            go = 1;
            cpu_req = '{1'b1, wr, tgt};
            dbg_mem_rdata = 8'($urandom);
            #1 check("cpu", cpu_grant, !(wr && k[3:1] inside {3'h5, 3'h6}));
            check("port", dbg_grant, port_ok(c[0], k[3:1]));
            check("corrupt", dbg_corrupt_read, !wr && !port_ok(c[0], k[3:1]));
            check("prog", dbg_fuse_prog_en,
               wr && port_ok(c[0], k[3:1]) && k[3:1] inside {3'h4, 3'h6});
            @(negedge mclk);
            if (!wr)
               check("rdata", dbg_rdata == dbg_mem_rdata, port_ok(c[0], k[3:1]));
         end
         go = 0;
         cpu_req = '0;
      end
      report_and_stop;
   end
endmodule
`default_nettype wire
